// file: logic/frs_fault_reset_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module frs_fault_reset_sequencer #(
   parameter int unsigned TICK_CYCLES = frs_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Configuration
   input wire logic autoResetEn,
   input wire logic [2:0] retryTimeSel,
   input wire logic [5:0] resetSrcSel,
   // Reset sources
   input wire logic [15:0] digitalIn,
   input wire logic [15:0] cmdBits,
   input wire logic keypadStopReset,
   input wire logic productRestart,
   // Drive condition
   input wire logic errorActive,
   input wire logic errorResettable,
   input wire logic startPermit,
   // Encoder counting
   input wire logic encPulse,
   input wire logic posReset,
   // Status
   output logic faultState,
   output logic faultRelay,
   output logic driveNormal,
   output logic retryActive,
   output logic retryLocked,
   output logic powerupBusy,
   output logic [31:0] encPulseCount,
   output logic [31:0] embEncPulseCount
);

   ////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   // Wait before the given attempt
   function automatic logic [23:0] waitMs(input logic [1:0] attempt);
      case (attempt)
         2'h0: waitMs = frs_pkg::WAIT_FIRST_MS;
         2'h1: waitMs = frs_pkg::WAIT_SECOND_MS;
         2'h2: waitMs = frs_pkg::WAIT_THIRD_MS;
         default: waitMs = frs_pkg::WAIT_LATER_MS;
      endcase
   endfunction

   // Maximum retry time for a selection code; unknown codes use the default
   function automatic logic [23:0] limitMs(input logic [2:0] sel);
      case (sel)
         frs_pkg::LIM_10MIN: limitMs = frs_pkg::LIMIT_10MIN_MS;
         frs_pkg::LIM_30MIN: limitMs = frs_pkg::LIMIT_30MIN_MS;
         frs_pkg::LIM_1H: limitMs = frs_pkg::LIMIT_1H_MS;
         frs_pkg::LIM_2H: limitMs = frs_pkg::LIMIT_2H_MS;
         frs_pkg::LIM_3H: limitMs = frs_pkg::LIMIT_3H_MS;
         default: limitMs = frs_pkg::LIMIT_5MIN_MS;
      endcase
   endfunction

   // Level of the selected manual reset source
   function automatic logic srcLevel(input logic [5:0] sel, input logic [15:0] di, input logic [15:0] cmd);
      logic [5:0] idx;
      idx = 6'h00;
      srcLevel = 1'b0;
      if (sel >= frs_pkg::SRC_DI_FIRST && sel <= frs_pkg::SRC_DI_LOW_LAST) begin
         idx = sel - frs_pkg::SRC_DI_FIRST;
         srcLevel = di[idx[3:0]];
      end else if (sel >= frs_pkg::SRC_DI_EXT_FIRST && sel <= frs_pkg::SRC_DI_EXT_LAST) begin
         idx = sel - frs_pkg::SRC_DI_FIRST;
         srcLevel = di[idx[3:0]];
      end else if (sel >= frs_pkg::SRC_CMD_FIRST && sel <= frs_pkg::SRC_CMD_LAST) begin
         idx = sel - frs_pkg::SRC_CMD_FIRST;
         srcLevel = cmd[idx[3:0]];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Source selection guard

   logic [5:0] selPrev, next_selPrev;
   logic selSettled;

   // A fresh source choice whose input already stands high is not a press
   always_comb begin
      next_selPrev = resetSrcSel;
      selSettled = (resetSrcSel == selPrev);
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         selPrev <= frs_pkg::SRC_RESET;
      end else begin
         selPrev <= next_selPrev;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge detection of reset requests

   logic srcPrev, keyPrev, restartPrev;
   logic next_srcPrev, next_keyPrev, next_restartPrev;
   logic manualReq, restartReq;

   // Rising edges of the selected source, keypad key and restart request
   always_comb begin
      next_srcPrev = srcLevel(resetSrcSel, digitalIn, cmdBits);
      next_keyPrev = keypadStopReset;
      next_restartPrev = productRestart;
      manualReq = (next_srcPrev && !srcPrev && selSettled) || (keypadStopReset && !keyPrev);
      restartReq = productRestart && !restartPrev;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         srcPrev <= 1'b1;
         keyPrev <= 1'b1;
         restartPrev <= 1'b1;
      end else begin
         srcPrev <= next_srcPrev;
         keyPrev <= next_keyPrev;
         restartPrev <= next_restartPrev;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Millisecond tick

   logic [15:0] tickCnt, next_tickCnt;
   logic msTick;

   // Divides the system clock down to one pulse per millisecond
   always_comb begin
      msTick = (tickCnt == 16'(TICK_CYCLES - 1));
      next_tickCnt = msTick ? 16'h0000 : tickCnt + 16'h0001;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tickCnt <= 16'h0000;
      end else begin
         tickCnt <= next_tickCnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault reset sequencer

   frs_pkg::frs_state_t state, next_state;
   logic [23:0] waitCnt, next_waitCnt;
   logic [23:0] totalCnt, next_totalCnt;
   logic [1:0] attempt, next_attempt;
   logic next_faultState, next_faultRelay;
   logic faultOut;

   // Next state, wait and limit timers
   always_comb begin
      next_state = state;
      next_waitCnt = waitCnt;
      next_totalCnt = totalCnt;
      next_attempt = attempt;
      case (state)
         frs_pkg::ST_NORMAL: begin
            next_waitCnt = 24'h00_0000;
            next_totalCnt = 24'h00_0000;
            next_attempt = 2'h0;
            if (errorActive) begin
               if (autoResetEn && errorResettable) begin
                  next_state = frs_pkg::ST_RETRY_WAIT;
               end else begin
                  next_state = frs_pkg::ST_FAULT_HOLD;
               end
            end
         end
         frs_pkg::ST_RETRY_WAIT: begin
            if (msTick) begin
               next_waitCnt = waitCnt + 24'h00_0001;
               next_totalCnt = totalCnt + 24'h00_0001;
            end
            // Limit is tested before the wait so a late attempt cannot outrun it
            if (!autoResetEn) begin
               next_state = frs_pkg::ST_FAULT_HOLD;
            end else if (retryTimeSel != frs_pkg::LIM_UNLIMITED && totalCnt >= limitMs(retryTimeSel)) begin
               next_state = frs_pkg::ST_LOCKED;
            end else if (waitCnt >= waitMs(attempt)) begin
               next_waitCnt = 24'h00_0000;
               if (attempt != frs_pkg::ATTEMPT_LAST) begin
                  next_attempt = attempt + 2'h1;
               end
               if (!errorActive && startPermit) begin
                  next_state = frs_pkg::ST_NORMAL;
               end
            end else if (manualReq && !errorActive) begin
               next_state = frs_pkg::ST_NORMAL;
            end
         end
         frs_pkg::ST_FAULT_HOLD: begin
            if (manualReq && errorResettable && !errorActive) begin
               next_state = frs_pkg::ST_NORMAL;
            end
         end
         frs_pkg::ST_LOCKED: begin
            next_state = frs_pkg::ST_LOCKED;
         end
         frs_pkg::ST_POWERUP: begin
            // Replays the power-up steps; attempts and limit start afresh
            next_attempt = 2'h0;
            next_totalCnt = 24'h00_0000;
            if (msTick) begin
               next_waitCnt = waitCnt + 24'h00_0001;
            end
            if (waitCnt >= frs_pkg::POWERUP_MS) begin
               next_waitCnt = 24'h00_0000;
               next_state = frs_pkg::ST_NORMAL;
            end
         end
         default: begin
            next_state = frs_pkg::ST_NORMAL;
         end
      endcase
      // Product restart clears every fault and replays power-up
      if (restartReq) begin
         next_state = frs_pkg::ST_POWERUP;
         next_waitCnt = 24'h00_0000;
         next_totalCnt = 24'h00_0000;
         next_attempt = 2'h0;
      end
      faultOut = (next_state == frs_pkg::ST_FAULT_HOLD) || (next_state == frs_pkg::ST_LOCKED);
      next_faultState = faultOut;
      next_faultRelay = autoResetEn || !faultOut;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= frs_pkg::ST_POWERUP;
         waitCnt <= 24'h00_0000;
         totalCnt <= 24'h00_0000;
         attempt <= 2'h0;
         faultState <= 1'b0;
         faultRelay <= 1'b1;
      end else begin
         state <= next_state;
         waitCnt <= next_waitCnt;
         totalCnt <= next_totalCnt;
         attempt <= next_attempt;
         faultState <= next_faultState;
         faultRelay <= next_faultRelay;
      end
   end

   // Status decoded from the state register
   assign driveNormal = (state == frs_pkg::ST_NORMAL);
   assign retryActive = (state == frs_pkg::ST_RETRY_WAIT);
   assign retryLocked = (state == frs_pkg::ST_LOCKED);
   assign powerupBusy = (state == frs_pkg::ST_POWERUP);

   ////////////////////////////////////////////////////////////////////////
   // Encoder pulse counters

   logic [31:0] next_encPulseCount, next_embEncPulseCount;

   // Counting pulses, zeroed by the position reset source
   always_comb begin
      next_encPulseCount = encPulseCount;
      next_embEncPulseCount = embEncPulseCount;
      if (posReset) begin
         next_encPulseCount = 32'h0000_0000;
         next_embEncPulseCount = 32'h0000_0000;
      end else if (encPulse) begin
         next_encPulseCount = encPulseCount + 32'h0000_0001;
         next_embEncPulseCount = embEncPulseCount + 32'h0000_0001;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         encPulseCount <= 32'h0000_0000;
         embEncPulseCount <= 32'h0000_0000;
      end else begin
         encPulseCount <= next_encPulseCount;
         embEncPulseCount <= next_embEncPulseCount;
      end
   end

endmodule
`default_nettype wire

// file: logic/frs_pkg.sv
`default_nettype none
package frs_pkg;
   // Clock and base tick
   localparam int unsigned SYS_CLK_HZ = 40_000_000;
   localparam int unsigned TICK_PERIOD_MS = 1;
   localparam int unsigned TICK_CYCLES = SYS_CLK_HZ / 1000 * TICK_PERIOD_MS;

   // Retry waits between automatic attempts, in ms
   localparam logic [23:0] WAIT_FIRST_MS = 24'h00_03E8;  // 1 s
   localparam logic [23:0] WAIT_SECOND_MS = 24'h00_1388; // 5 s
   localparam logic [23:0] WAIT_THIRD_MS = 24'h00_2710;  // 10 s
   localparam logic [23:0] WAIT_LATER_MS = 24'h00_EA60;  // 1 minute

   // Maximum retry time settings, in ms
   localparam logic [23:0] LIMIT_5MIN_MS = 24'h04_93E0;
   localparam logic [23:0] LIMIT_10MIN_MS = 24'h09_27C0;
   localparam logic [23:0] LIMIT_30MIN_MS = 24'h1B_7740;
   localparam logic [23:0] LIMIT_1H_MS = 24'h36_EE80;
   localparam logic [23:0] LIMIT_2H_MS = 24'h6D_DD00;
   localparam logic [23:0] LIMIT_3H_MS = 24'hA4_CB80;

   // Length of the power-up sequence replayed on product restart, in ms
   localparam logic [23:0] POWERUP_MS = 24'h00_0064;

   // Retry time selection codes
   localparam logic [2:0] LIM_5MIN = 3'h0;
   localparam logic [2:0] LIM_10MIN = 3'h1;
   localparam logic [2:0] LIM_30MIN = 3'h2;
   localparam logic [2:0] LIM_1H = 3'h3;
   localparam logic [2:0] LIM_2H = 3'h4;
   localparam logic [2:0] LIM_3H = 3'h5;
   localparam logic [2:0] LIM_UNLIMITED = 3'h6;
   localparam logic [2:0] LIM_RESET = LIM_5MIN;

   // Manual reset source selection codes
   localparam logic [5:0] SRC_NONE = 6'h00;
   localparam logic [5:0] SRC_DI_FIRST = 6'h01;
   localparam logic [5:0] SRC_DI_LOW_LAST = 6'h08;
   localparam logic [5:0] SRC_DI_EXT_FIRST = 6'h0B;
   localparam logic [5:0] SRC_DI_EXT_LAST = 6'h10;
   localparam logic [5:0] SRC_CMD_FIRST = 6'h20;
   localparam logic [5:0] SRC_CMD_LAST = 6'h2F;
   localparam logic [5:0] SRC_RESET = 6'h04;

   // Attempt counter saturation
   localparam logic [1:0] ATTEMPT_LAST = 2'h3;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_RETRY_WAIT,
      ST_FAULT_HOLD,
      ST_LOCKED,
      ST_POWERUP
   } frs_state_t;
endpackage
`default_nettype wire

// file: tb/frs_operator.sv
`timescale 1ns/10ps
`default_nettype none
module frs_operator (
   // Clock
   input wire logic sys_clk,
   // Request from the bench
   input wire logic press,
   input wire logic [5:0] sel,
   // Reset sources toward the block
   output logic [15:0] digitalIn,
   output logic [15:0] cmdBits,
   output logic keypadStopReset
);
   logic [1:0] hold = 2'h0;
   // Keeps a press up for three cycles, then lets it go
   always @(posedge sys_clk) begin
      if (press) hold <= 2'h3;
      else if (hold != 2'h0) hold <= hold - 2'h1;
   end
   // Level, active-high source; reference and direction never move
   always_comb begin
      digitalIn = 16'h0000;
      cmdBits = 16'h0000;
      keypadStopReset = 1'b0;
      if (hold != 2'h0) begin
         if (sel == 6'h3F) keypadStopReset = 1'b1;
         else if (sel >= 6'h20) cmdBits[sel[3:0]] = 1'b1;
         else if (sel != 6'h00) digitalIn[sel[3:0] - 4'h1] = 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: tb/frs_fault_reset_sequencer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module frs_fault_reset_sequencer_assertions (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Causes
   input wire logic autoResetEn,
   input wire logic errorActive,
   input wire logic errorResettable,
   input wire logic productRestart,
   input wire logic encPulse,
   input wire logic posReset,
   // Effects
   input wire logic faultState,
   input wire logic faultRelay,
   input wire logic driveNormal,
   input wire logic retryActive,
   input wire logic retryLocked,
   input wire logic powerupBusy,
   input wire logic [31:0] encPulseCount
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////
   // State outputs against their causes
   relay_on_a: assert property ($past(autoResetEn) |-> faultRelay)
      else $error("relay dropped");
   retry_quiet_a: assert property (retryActive |-> !faultState)
      else $error("fault shown in retry");
   auto_entry_a: assert property (driveNormal && errorActive && autoResetEn && errorResettable && !productRestart
      |=> retryActive) else $error("no retry");
   hard_error_a: assert property (driveNormal && errorActive && !errorResettable && !productRestart
      |=> faultState) else $error("hard error not held");
   resume_cause_a: assert property ($rose(driveNormal) && $past(retryActive) |-> !$past(errorActive))
      else $error("resumed with error");
   hold_refuse_a: assert property (faultState && errorActive && !productRestart |=> faultState)
      else $error("fault cleared early");
   lock_hold_a: assert property (retryLocked && !productRestart |=> retryLocked && faultState)
      else $error("lock left");
   restart_go_a: assert property ($rose(productRestart) && !$past(sys_rst) |-> ##[1:2] powerupBusy)
      else $error("no restart");
   powerup_end_a: assert property ($fell(powerupBusy) |-> driveNormal)
      else $error("bad power-up end");
   pos_clear_a: assert property (posReset |=> encPulseCount == 32'h0000_0000)
      else $error("count not cleared");
endmodule
bind frs_fault_reset_sequencer frs_fault_reset_sequencer_assertions i_frs_fault_reset_sequencer_assertions (
   .sys_clk, .sys_rst, .autoResetEn, .errorActive, .errorResettable, .productRestart, .encPulse, .posReset,
   .faultState, .faultRelay, .driveNormal, .retryActive, .retryLocked, .powerupBusy, .encPulseCount);
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic sys_clk = 0, sys_rst = 1, autoResetEn = 0, productRestart = 0, errorActive = 0, errorResettable = 1;
   logic startPermit = 1, encPulse = 0, posReset = 0, press = 0, keypadStopReset;
   logic [5:0] resetSrcSel = frs_pkg::SRC_RESET, sel = 6'h04;
   logic [2:0] retryTimeSel = frs_pkg::LIM_RESET;
   logic [5:0] srcs [5] = '{6'h04, 6'h08, 6'h0B, 6'h2F, 6'h3F};
   logic [15:0] digitalIn, cmdBits;
   logic faultState, faultRelay, driveNormal, retryActive, retryLocked, powerupBusy;
   logic [31:0] encPulseCount, embEncPulseCount;
   int failures = 0, check_count = 0, c;
   // Block under test and the operator beside it
   frs_fault_reset_sequencer #(.TICK_CYCLES(1)) i_frs_fault_reset_sequencer (.sys_clk, .sys_rst, .autoResetEn,
      .retryTimeSel, .resetSrcSel, .digitalIn, .cmdBits, .keypadStopReset, .productRestart,
      .errorActive, .errorResettable, .startPermit, .encPulse, .posReset, .faultState, .faultRelay,
      .driveNormal, .retryActive, .retryLocked, .powerupBusy, .encPulseCount, .embEncPulseCount);
   frs_operator i_frs_operator (.sys_clk, .press, .sel, .digitalIn, .cmdBits, .keypadStopReset);
   initial forever #12.5 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic test_done;
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wn(input int m);
      c = 0;
      while (driveNormal !== 1'b1 && c < m) begin
         cyc(1);
         c++;
      end
      if (c >= m) begin
         failures++;
         test_done();
      end
   endtask
   task automatic push(input logic [5:0] s);
      @(posedge sys_clk) press <= 1'b1;
      sel <= s;
      @(posedge sys_clk) press <= 1'b0;
      cyc(6);
   endtask
   task automatic fault(input logic keep);
      @(posedge sys_clk) errorActive <= 1'b1;
      cyc(3);
      @(posedge sys_clk) errorActive <= keep;
      cyc(1);
   endtask
   ////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_enc;
      @(posedge sys_clk) posReset <= 1'b1;
      @(posedge sys_clk) posReset <= 1'b0;
      encPulse <= 1'b1;
      repeat (5) @(posedge sys_clk);
      encPulse <= 1'b0;
      cyc(2);
      chk(encPulseCount, 32'h0000_0005);
      @(posedge sys_clk) posReset <= 1'b1;
      cyc(2);
      chk(embEncPulseCount, 32'h0000_0000);
      @(posedge sys_clk) posReset <= 1'b0;
   endtask
   task automatic t_auto;
      @(posedge sys_clk) autoResetEn <= 1'b1;
      @(posedge sys_clk) errorActive <= 1'b1;
      cyc(3);
      chk({retryActive, faultState, faultRelay}, 3'b101);
      cyc(1200);
      chk({retryActive, driveNormal, retryLocked}, 3'b100);
      @(posedge sys_clk) errorActive <= 1'b0;
      wn(6000);
      chk(c > 4789 && c < 4807, 1);
      @(posedge sys_clk) errorActive <= 1'b1;
      cyc(10);
      @(posedge sys_clk) errorActive <= 1'b0;
      wn(2000);
      chk(c > 979 && c < 1001, 1);
      @(posedge sys_clk) errorActive <= 1'b1;
      retryTimeSel <= frs_pkg::LIM_UNLIMITED;
      cyc(10);
      @(posedge sys_clk) errorActive <= 1'b0;
      startPermit <= 1'b0;
      cyc(1100);
      chk({retryActive, retryLocked}, 2'b10);
      push(6'h3F);
      chk(driveNormal, 1'b1);
      @(posedge sys_clk) startPermit <= 1'b1;
      retryTimeSel <= frs_pkg::LIM_RESET;
   endtask
   task automatic t_manual;
      @(posedge sys_clk) autoResetEn <= 1'b0;
      fault(1'b1);
      chk({faultState, faultRelay}, 2'b10);
      push(6'h04);
      chk(faultState, 1'b1);
      @(posedge sys_clk) errorActive <= 1'b0;
      resetSrcSel <= frs_pkg::SRC_NONE;
      push(6'h04);
      chk(faultState, 1'b1);
      foreach (srcs[i]) begin
         @(posedge sys_clk) resetSrcSel <= (srcs[i] == 6'h3F) ? frs_pkg::SRC_NONE : srcs[i];
         fault(1'b0);
         push(srcs[i]);
         chk(driveNormal, 1'b1);
      end
   endtask
   task automatic t_restart;
      @(posedge sys_clk) errorResettable <= 1'b0;
      autoResetEn <= 1'b1;
      fault(1'b0);
      push(6'h3F);
      chk({faultState, retryActive}, 2'b10);
      @(posedge sys_clk) productRestart <= 1'b1;
      errorResettable <= 1'b1;
      cyc(3);
      chk({powerupBusy, faultState}, 2'b10);
      @(posedge sys_clk) productRestart <= 1'b0;
      wn(300);
      chk(c > 95 && c < 101, 1);
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      chk(powerupBusy, 1'b1);
      sys_rst <= 1'b0;
      wn(300);
      chk(c > 98 && c < 104, 1);
      t_enc();
      t_auto();
      t_manual();
      t_restart();
      test_done();
   end
endmodule
`default_nettype wire
